// ---- design/zlf_defs.svh ----
// Constants for the zero-latency FIFO: sizes, thresholds, register map.
// Assumes inclusion by bare name; definitions only.
`ifndef ZLF_DEFS_SVH
`define ZLF_DEFS_SVH

// Array shape
`define ZLF_DEPTH      128
`define ZLF_AW         7
`define ZLF_PW         8
`define ZLF_DW         5

// Fill thresholds and the full count
`define ZLF_LVL_LOW    8'h20
`define ZLF_LVL_HIGH   8'h60
`define ZLF_FULL_CNT   8'h80

// Register byte offsets
`define ZLF_OFS_STATUS 8'h00
`define ZLF_OFS_MASK   8'h04
`define ZLF_OFS_FILL   8'h08
`define ZLF_OFS_PINS   8'h0C

// Event bit positions in status and mask
`define ZLF_EV_EMPTY   0
`define ZLF_EV_FULL    1
`define ZLF_EV_LEVEL   2
`define ZLF_EV_W       3
`define ZLF_MASK_RST   3'h0

// Pin synchroniser width and its reset pattern
`define ZLF_SYNC_W     10
`define ZLF_SYNC_INIT  10'h260

`endif

// ---- design/zlf_pkg.sv ----
// Types shared by the zero-latency FIFO modules.
// Assumes zlf_defs.svh is on the include path.
`include "zlf_defs.svh"

package zlf_pkg;

  typedef logic [`ZLF_DW-1:0]     zlf_word_t;
  // One spare bit beyond the address tells full from empty
  typedef logic [`ZLF_PW-1:0]     zlf_ptr_t;
  typedef logic [`ZLF_EV_W-1:0]   zlf_evt_t;
  typedef logic [7:0]             zlf_addr_t;
  typedef logic [31:0]            zlf_data_t;
  typedef logic [`ZLF_SYNC_W-1:0] zlf_sync_t;

  typedef struct packed {
    zlf_sync_t ff1;
    zlf_sync_t ff2;
    zlf_sync_t ff3;
    zlf_sync_t stab;
  } zlf_sync_s;

  typedef struct packed {
    zlf_ptr_t  wr_ptr;
    zlf_ptr_t  rd_ptr;
    logic      push_q;
    logic      pop_q;
    zlf_word_t q_r;
    logic      oe_n;
    logic      empty_n;
    logic      room_n;
    logic      mark;
    zlf_evt_t  status;
    zlf_evt_t  mask;
    zlf_data_t rdata;
  } zlf_core_s;

endpackage : zlf_pkg

// ---- design/zlf_sync.sv ----
// Three-stage synchroniser for the asynchronous pins of the FIFO.
// Assumes one clock; a bit changes once stages two and three agree.
`timescale 1ns/1ps
`include "zlf_defs.svh"

module zlf_sync (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Raw pins and their settled copies
  input  wire zlf_pkg::zlf_sync_t pin_in,
  output      zlf_pkg::zlf_sync_t pin_stable
);
  import zlf_pkg::*;

  zlf_sync_s s_r;
  zlf_sync_s s_nxt;
  zlf_sync_t stab_nxt;

  // Per bit: stage one is read by stage two only
  genvar i;
  generate
    for (i = 0; i < `ZLF_SYNC_W; i = i + 1) begin : g_bit
      assign stab_nxt[i] = (s_r.ff2[i] == s_r.ff3[i]) ? s_r.ff3[i] : s_r.stab[i];
    end
  endgenerate

  // Next state of the chain
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ff1  = pin_in;
    s_nxt.ff2  = s_r.ff1;
    s_nxt.ff3  = s_r.ff2;
    s_nxt.stab = stab_nxt;
  end

  // Reset pattern keeps clear asserted and strobes high until settled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= {4{`ZLF_SYNC_INIT}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_stable = s_r.stab;

endmodule : zlf_sync

// ---- design/zlf_fifo.sv ----
// Zero-latency 128-word FIFO with strobe-driven push and pop sides.
// Assumes pins arrive from outside this clock; registers on a plain port.
//
// Summary of operation
// - Dual-port 128-word array, separate write/read pointers.
// - Words leave in order; both sides run independently.
// - Word written while push strobe is low.
// - Write pointer starts zero, steps on push rise.
// - Push rise captures only when not full.
// - Pop rise steps read pointer unless empty.
// - Word into empty buffer shows within a cycle.
// - Empty flag low on last read or reset.
// - Full flag low when write fills; vacancy releases.
// - Level mark at 32 or 96 by threshold pick.
// - Master clear low holds pointers zero, empty.
// - Output bus driven only while drive pin low.
// - Both pointers wrap last location to first.
// - Push edges ignored while full; pointer holds.
// - Pop edges ignored while empty; pointer holds.
// - Strobes ignored during master clear.
`timescale 1ns/1ps
`include "zlf_defs.svh"

module zlf_fifo (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Write side pins
  input  wire logic              push_strobe,
  input  wire zlf_pkg::zlf_word_t push_data,
  // Read side pins
  input  wire logic              pop_strobe,
  input  wire logic              q_drive_n,
  output      zlf_pkg::zlf_word_t q_data,
  output      logic              q_oe_n,
  // Control and status pins
  input  wire logic              master_clear_n,
  input  wire logic              threshold_pick,
  output      logic              no_words_n,
  output      logic              no_room_n,
  output      logic              level_mark,
  // Register port
  input  wire zlf_pkg::zlf_addr_t reg_addr,
  input  wire zlf_pkg::zlf_data_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output      zlf_pkg::zlf_data_t reg_rdata,
  // Interrupt
  output      logic              irq
);
  import zlf_pkg::*;

  // Storage and state
  zlf_word_t mem [0:`ZLF_DEPTH-1];
  zlf_core_s s_r;
  zlf_core_s s_nxt;

  // Raw and settled pin values
  zlf_sync_t pins_raw;
  zlf_sync_t pins_s;
  zlf_word_t d_s;
  logic      push_s;
  logic      pop_s;
  logic      clr_n_s;
  logic      pick_s;
  logic      drive_n_s;

  // Decoded events and helpers
  logic      push_rise;
  logic      pop_rise;
  logic      do_push;
  logic      do_pop;
  logic      wr_en;
  zlf_ptr_t  cnt;
  zlf_ptr_t  cnt_nxt;
  zlf_ptr_t  thresh;
  zlf_evt_t  evt;
  zlf_evt_t  clr_bits;
  zlf_data_t rd_mux;

  // Pins into one bundle so they share one synchroniser
  assign pins_raw = {q_drive_n, threshold_pick, master_clear_n,
                     pop_strobe, push_strobe, push_data};

  zlf_sync u_sync (
    .clock      (clock),
    .rst_n      (rst_n),
    .pin_in     (pins_raw),
    .pin_stable (pins_s)
  );

  // Unpack the settled pins
  assign d_s       = pins_s[`ZLF_DW-1:0];
  assign push_s    = pins_s[5];
  assign pop_s     = pins_s[6];
  assign clr_n_s   = pins_s[7];
  assign pick_s    = pins_s[8];
  assign drive_n_s = pins_s[9];

  // Edge detection on settled strobes only
  assign push_rise = push_s & ~s_r.push_q;
  assign pop_rise  = pop_s & ~s_r.pop_q;

  // Full and empty gate the edges; clear blocks both
  assign do_push = push_rise & s_r.room_n & clr_n_s;
  assign do_pop  = pop_rise & s_r.empty_n & clr_n_s;

  // Array is written for as long as the strobe stays low
  assign wr_en = ~push_s & s_r.room_n & clr_n_s;

  // Stored-word count from the pointer difference
  assign cnt = s_r.wr_ptr - s_r.rd_ptr;

  // Threshold picked by the settled select pin
  assign thresh = pick_s ? `ZLF_LVL_HIGH : `ZLF_LVL_LOW;

  // Write port of the array
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[s_r.wr_ptr[`ZLF_AW-1:0]] <= d_s;
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      `ZLF_OFS_STATUS: rd_mux[`ZLF_EV_W-1:0] = s_r.status;
      `ZLF_OFS_MASK:   rd_mux[`ZLF_EV_W-1:0] = s_r.mask;
      `ZLF_OFS_FILL:   rd_mux[`ZLF_PW-1:0]   = cnt;
      `ZLF_OFS_PINS:   rd_mux[3:0] = {pick_s, s_r.mark, s_r.room_n, s_r.empty_n};
      default:         rd_mux = '0;
    endcase
  end

  // Write-one-to-clear mask for the status register
  assign clr_bits = (reg_wr && reg_addr == `ZLF_OFS_STATUS) ?
                    reg_wdata[`ZLF_EV_W-1:0] : '0;

  // Main next-state logic
  always_comb begin
    s_nxt        = s_r;
    s_nxt.push_q = push_s;
    s_nxt.pop_q  = pop_s;
    s_nxt.oe_n   = drive_n_s;
    s_nxt.rdata  = reg_rd ? rd_mux : '0;

    // Pointers step on accepted edges; the spare bit makes the wrap
    if (!clr_n_s) begin
      s_nxt.wr_ptr = '0;
      s_nxt.rd_ptr = '0;
    end else begin
      if (do_push) begin
        s_nxt.wr_ptr = s_r.wr_ptr + 8'h01;
      end
      if (do_pop) begin
        s_nxt.rd_ptr = s_r.rd_ptr + 8'h01;
      end
    end

    // Flags follow the next count so they settle with the pointers
    cnt_nxt       = s_nxt.wr_ptr - s_nxt.rd_ptr;
    s_nxt.empty_n = (cnt_nxt != 8'h00);
    s_nxt.room_n  = (cnt_nxt != `ZLF_FULL_CNT);
    s_nxt.mark    = (cnt_nxt >= thresh);

    // Next word on the bus; an empty buffer shows the word being written
    s_nxt.q_r = mem[s_nxt.rd_ptr[`ZLF_AW-1:0]];
    if (wr_en && s_nxt.rd_ptr == s_r.wr_ptr) begin
      s_nxt.q_r = d_s;
    end

    // Sticky events; a new event beats a clear in the same cycle
    evt = '0;
    evt[`ZLF_EV_EMPTY] = s_r.empty_n & ~s_nxt.empty_n;
    evt[`ZLF_EV_FULL]  = s_r.room_n & ~s_nxt.room_n;
    evt[`ZLF_EV_LEVEL] = ~s_r.mark & s_nxt.mark;
    s_nxt.status = (s_r.status & ~clr_bits) | evt;

    // Mask enables the interrupt per event
    if (reg_wr && reg_addr == `ZLF_OFS_MASK) begin
      s_nxt.mask = reg_wdata[`ZLF_EV_W-1:0];
    end
  end

  // State register; reset shows an empty, undriven buffer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.push_q  <= 1'b1;
      s_r.pop_q   <= 1'b1;
      s_r.oe_n    <= 1'b1;
      s_r.room_n  <= 1'b1;
      s_r.mask    <= `ZLF_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs, all from flip-flops except the interrupt gate
  assign q_data     = s_r.q_r;
  assign q_oe_n     = s_r.oe_n;
  assign no_words_n = s_r.empty_n;
  assign no_room_n  = s_r.room_n;
  assign level_mark = s_r.mark;
  assign reg_rdata  = s_r.rdata;
  assign irq        = |(s_r.status & s_r.mask);

  // Full buffer must not move the write pointer
  a_push_full_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (push_rise && !s_r.room_n && clr_n_s) |=> (s_r.wr_ptr == $past(s_r.wr_ptr)))
    else $error("write pointer moved while full");

  // Empty buffer must not move the read pointer
  a_pop_empty_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (pop_rise && !s_r.empty_n && clr_n_s) |=> (s_r.rd_ptr == $past(s_r.rd_ptr)))
    else $error("read pointer moved while empty");

  // Accepted push with no pop raises the count by exactly one
  a_push_step: assert property (@(posedge clock) disable iff (!rst_n)
    (do_push && !do_pop) |=> (cnt == $past(cnt) + 8'h01))
    else $error("push did not raise count by one");

  // Accepted pop steps the read pointer by exactly one
  a_pop_step: assert property (@(posedge clock) disable iff (!rst_n)
    do_pop |=> (s_r.rd_ptr == $past(s_r.rd_ptr) + 8'h01))
    else $error("pop did not step read pointer");

  // Empty flag tracks a zero count
  a_empty_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (cnt == 8'h00) == !no_words_n)
    else $error("empty flag disagrees with count");

  // Full flag tracks a count of 128
  a_full_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (cnt == `ZLF_FULL_CNT) == !no_room_n)
    else $error("full flag disagrees with count");

  // Level mark matches the count once the pick has been stable two cycles
  a_level_mark: assert property (@(posedge clock) disable iff (!rst_n)
    $stable(pick_s) ##1 $stable(pick_s)
      |-> level_mark == (cnt >= (pick_s ? 8'h60 : 8'h20)))
    else $error("level mark wrong for count");

  // Clear held for two cycles leaves the buffer empty
  a_clear_empty: assert property (@(posedge clock) disable iff (!rst_n)
    (!clr_n_s [*2]) |-> (s_r.wr_ptr == 8'h00 && s_r.rd_ptr == 8'h00 && !no_words_n))
    else $error("clear did not empty the buffer");

  // Count just after an accepted push never exceeds the array depth
  a_count_max: assert property (@(posedge clock) disable iff (!rst_n)
    $past(do_push) |-> cnt <= `ZLF_FULL_CNT)
    else $error("count above depth");

  // Bus released within one cycle of the drive pin going high
  a_drive_off: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(drive_n_s) |=> q_oe_n)
    else $error("bus still driven after disable");

  // Behavioural checks on flags, pointers and the head word; those without
  // do_push or do_pop are written against the registered state so a broken gate shows up

  // Empty buffer with push low shows the word being written
  a_bypass_word: assert property (@(posedge clock) disable iff (!rst_n)
    (!push_s && clr_n_s && !s_r.empty_n) |=> (q_data == $past(d_s)))
    else $error("head word not transparent while empty");

  // First accepted write lifts the empty flag
  a_first_word: assert property (@(posedge clock) disable iff (!rst_n)
    (do_push && !s_r.empty_n) |=> no_words_n)
    else $error("empty flag stuck after first write");

  // Reading the last word drops the empty flag
  a_last_word: assert property (@(posedge clock) disable iff (!rst_n)
    (do_pop && !do_push && cnt == 8'h01) |=> !no_words_n)
    else $error("empty flag high after last read");

  // Write of the last vacancy drops the full flag
  a_full_on_write: assert property (@(posedge clock) disable iff (!rst_n)
    (do_push && !do_pop && cnt == 8'h7F) |=> !no_room_n)
    else $error("full flag high after filling write");

  // Read from a full buffer releases the full flag
  a_vacancy_room: assert property (@(posedge clock) disable iff (!rst_n)
    (do_pop && !s_r.room_n) |=> no_room_n)
    else $error("full flag stuck after read");

  // Clear forces both pointers to zero on the next edge
  a_clear_ptrs: assert property (@(posedge clock) disable iff (!rst_n)
    !clr_n_s |=> (s_r.wr_ptr == 8'h00 && s_r.rd_ptr == 8'h00))
    else $error("pointers moved during clear");

  // Write pointer wraps from the last location to the first
  a_wr_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (do_push && s_r.wr_ptr[`ZLF_AW-1:0] == 7'h7F) |=> (s_r.wr_ptr[`ZLF_AW-1:0] == 7'h00))
    else $error("write pointer did not wrap");

  // Read pointer wraps from the last location to the first
  a_rd_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (do_pop && s_r.rd_ptr[`ZLF_AW-1:0] == 7'h7F) |=> (s_r.rd_ptr[`ZLF_AW-1:0] == 7'h00))
    else $error("read pointer did not wrap");

  // Lone pop lowers the count by one
  a_pop_count: assert property (@(posedge clock) disable iff (!rst_n)
    (do_pop && !do_push) |=> (cnt == $past(cnt) - 8'h01))
    else $error("pop did not lower count by one");

  // Push and pop in one cycle leave the count alone
  a_both_count: assert property (@(posedge clock) disable iff (!rst_n)
    (do_push && do_pop) |=> (cnt == $past(cnt)))
    else $error("concurrent push and pop changed count");

  // No accepted edge, no clear: the count holds
  a_idle_count: assert property (@(posedge clock) disable iff (!rst_n)
    (!do_push && !do_pop && clr_n_s) |=> (cnt == $past(cnt)))
    else $error("count moved without an edge");

  // Mark never high below the lower threshold
  a_mark_floor: assert property (@(posedge clock) disable iff (!rst_n)
    level_mark |-> (cnt >= 8'h20))
    else $error("level mark high below 32 words");

  // Mark never low at or above the upper threshold
  a_mark_ceiling: assert property (@(posedge clock) disable iff (!rst_n)
    !level_mark |-> (cnt < 8'h60))
    else $error("level mark low at 96 words or more");

  // Bus driven within one cycle of the drive pin going low
  a_drive_on: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(drive_n_s) |=> !q_oe_n)
    else $error("bus not driven after enable");

  // Rise with room and no clear steps the write pointer
  a_push_accept: assert property (@(posedge clock) disable iff (!rst_n)
    (push_rise && s_r.room_n && clr_n_s) |=> (s_r.wr_ptr == $past(s_r.wr_ptr) + 8'h01))
    else $error("accepted push did not step pointer");

  // Without an accepted pop the read pointer holds
  a_rd_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!do_pop && clr_n_s) |=> (s_r.rd_ptr == $past(s_r.rd_ptr)))
    else $error("read pointer moved without pop");

  // Without an accepted push the write pointer holds
  a_wr_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!do_push && clr_n_s) |=> (s_r.wr_ptr == $past(s_r.wr_ptr)))
    else $error("write pointer moved without push");

endmodule : zlf_fifo

// ---- verif/zlf_pin_agent.sv ----
// Writer and reader pin model for the zero-latency FIFO.
// Assumes the bench calls its tasks just after a clock edge; 160 ns strobe period.
`timescale 1ns/1ps

module zlf_pin_agent (
  // Clock
  input  wire logic               clock,
  // Pins toward the FIFO
  output      logic               push_strobe,
  output      zlf_pkg::zlf_word_t push_data,
  output      logic               pop_strobe
);
  import zlf_pkg::*;
  localparam int HALF = 10; // 80 ns per phase

  // Idle high so every cycle starts with a clean low phase
  initial begin
    push_strobe = 1'b1;
    pop_strobe  = 1'b1;
    push_data   = '0;
  end

  // Low phase stores the word, the rise ends the write
  task automatic push(input zlf_word_t w);
    push_strobe <= 1'b0;
    push_data   <= w;
    repeat (HALF) @(posedge clock);
    push_strobe <= 1'b1;
    repeat (HALF / 2) @(posedge clock);
    // Hold has run out, so show a changed value, not the old word
    push_data <= ~w;
    repeat (HALF / 2) @(posedge clock);
  endtask : push

  // The rise of the strobe takes the word
  task automatic pop();
    pop_strobe <= 1'b0;
    repeat (HALF) @(posedge clock);
    pop_strobe <= 1'b1;
    repeat (HALF) @(posedge clock);
  endtask : pop
endmodule : zlf_pin_agent

// ---- verif/zlf_fifo_tb.sv ----
// Self-checking bench for the zero-latency FIFO: pins, flags, registers, interrupt.
// Assumes zlf_pkg and zlf_pin_agent are compiled first.
`timescale 1ns/1ps
`include "zlf_defs.svh"

module zlf_fifo_tb;
  import zlf_pkg::*;
  logic        clock, rst_n, push_strobe, pop_strobe, q_drive_n, q_oe_n, irq;
  logic        master_clear_n, threshold_pick, no_words_n, no_room_n, level_mark;
  logic        reg_wr, reg_rd;
  zlf_word_t   push_data, q_data;
  zlf_addr_t   reg_addr;
  zlf_data_t   reg_wdata, reg_rdata;
  int          n_errors, checked, n, i;
  logic [31:0] seed;
  zlf_word_t   q[$];

  zlf_fifo u_zlf_fifo (.clock, .rst_n, .push_strobe, .push_data, .pop_strobe, .q_drive_n,
    .q_data, .q_oe_n, .master_clear_n, .threshold_pick, .no_words_n, .no_room_n,
    .level_mark, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  zlf_pin_agent u_zlf_pin_agent (.clock, .push_strobe, .push_data, .pop_strobe);

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic mark_exp(input int c, input logic p);
    return c >= (p ? 96 : 32);
  endfunction : mark_exp

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Register write, one strobe cycle
  task automatic rwr(input zlf_addr_t a, input zlf_data_t d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : rwr

  // Register read; data stands only in the following cycle
  task automatic rchk(input string nm, input zlf_addr_t a, input zlf_data_t exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
    tick(1);
  endtask : rchk

  // Flags and head word against the model count
  task automatic flags(input int c);
    chk("no_words_n", no_words_n, c != 0);
    chk("no_room_n", no_room_n, c != 128);
    chk("level_mark", level_mark, mark_exp(c, threshold_pick));
    if (c != 0) chk("q_data", q_data, q[0]);
  endtask : flags

  // Random word and random threshold; upd=0 when the write must be refused
  task automatic wr1(input logic upd);
    zlf_word_t w;
    seed = lfsr(seed);
    w = seed[4:0];
    threshold_pick <= seed[8];
    u_zlf_pin_agent.push(w);
    if (upd) q.push_back(w);
  endtask : wr1

  task automatic rd1();
    u_zlf_pin_agent.pop();
    if (q.size() > 0) void'(q.pop_front());
  endtask : rd1

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Watchdog well past the expected run of about 6100 cycles
  initial begin
    tick(40000);
    n_errors++;
    results();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, threshold_pick} = 4'h0;
    {master_clear_n, q_drive_n} = 2'h2;
    reg_addr  = '0;
    reg_wdata = '0;
    n_errors  = 0;
    checked   = 0;
    seed      = 32'h8EC64079;
    tick(4);
    rst_n <= 1'b1;
    tick(10);
    flags(0);
    chk("irq", irq, 0);
    rwr(`ZLF_OFS_STATUS, 32'h7);
    rchk("unmapped", 8'h10, 0);
    $display("test reset done");
    // Fill to full with a live threshold, then one refused write
    for (n = 1; n <= 128; n++) begin
      wr1(1);
      flags(n);
    end
    wr1(0);
    flags(128);
    rchk("fill", `ZLF_OFS_FILL, 128);
    rchk("status", `ZLF_OFS_STATUS, 6);
    rchk("pins", `ZLF_OFS_PINS, {28'h0, threshold_pick, 3'h5});
    $display("test fill done");
    // Drain, then one pop that must be ignored
    for (n = 127; n >= 0; n--) begin
      rd1();
      flags(n);
    end
    rd1();
    flags(0);
    $display("test drain done");
    // Mixed and concurrent traffic, starting with both pointers just past the wrap
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      if (q.size() < 2) begin
        wr1(1);
      end else if (seed[1]) begin
        rd1();
      end else begin
        fork
          wr1(1);
          u_zlf_pin_agent.pop();
        join
        void'(q.pop_front());
      end
      flags(q.size());
    end
    q_drive_n <= 1'b1;
    tick(10);
    chk("q_oe_n", q_oe_n, 1);
    q_drive_n <= 1'b0;
    tick(10);
    chk("q_oe_n", q_oe_n, 0);
    $display("test mixed done");
    // Master clear with a write attempted during it
    rwr(`ZLF_OFS_STATUS, 32'h7);
    master_clear_n <= 1'b0;
    q.delete();
    wr1(0);
    flags(0);
    master_clear_n <= 1'b1;
    tick(10);
    rchk("fill", `ZLF_OFS_FILL, 0);
    rchk("status", `ZLF_OFS_STATUS, 1);
    chk("irq", irq, 0);
    rwr(`ZLF_OFS_MASK, 32'h1);
    chk("irq", irq, 1);
    rchk("mask", `ZLF_OFS_MASK, 32'h1);
    rwr(`ZLF_OFS_STATUS, 32'h1);
    chk("irq", irq, 0);
    // Head word follows the pin while the empty buffer is written
    fork
      wr1(1);
      begin
        tick(8);
        chk("q_through", q_data, push_data);
        chk("no_words_n", no_words_n, 0);
      end
    join
    flags(1);
    $display("test clear done");
    results();
  end
endmodule : zlf_fifo_tb
